// [rtl/gpcn_pkg.sv]
// constants and carrier types for the gpio port with change notification
package gpcn_pkg;

  localparam int          GPCN_PINS       = 16;

  // register byte offsets (base registers)
  localparam logic [11:0] GPCN_OFF_ANALOG = 12'h000;
  localparam logic [11:0] GPCN_OFF_DIR    = 12'h010;
  localparam logic [11:0] GPCN_OFF_LEVEL  = 12'h020;
  localparam logic [11:0] GPCN_OFF_LATCH  = 12'h030;
  localparam logic [11:0] GPCN_OFF_ODC    = 12'h040;
  localparam logic [11:0] GPCN_OFF_PU     = 12'h050;
  localparam logic [11:0] GPCN_OFF_PD     = 12'h060;
  localparam logic [11:0] GPCN_OFF_CNCTL  = 12'h070;
  localparam logic [11:0] GPCN_OFF_CNEN   = 12'h080;
  localparam logic [11:0] GPCN_OFF_CNSTAT = 12'h090;

  // companion offsets added to a base offset
  localparam logic [11:0] GPCN_OFF_CLR    = 12'h004;
  localparam logic [11:0] GPCN_OFF_SET    = 12'h008;
  localparam logic [11:0] GPCN_OFF_INV    = 12'h00C;

  // field positions
  localparam int          GPCN_CNON_BIT   = 15;

  // values after reset
  localparam logic [15:0] GPCN_RST_ANALOG = 16'hFFFF;
  localparam logic [15:0] GPCN_RST_DIR    = 16'hFFFF;
  localparam logic [15:0] GPCN_RST_ZERO   = 16'h0000;

  // kind of register access, taken from address bits 3:2
  typedef enum logic [1:0] {
    GPCN_OP_WRITE,
    GPCN_OP_CLR,
    GPCN_OP_SET,
    GPCN_OP_INV
  } gpcn_op_t;

  // per-pin configuration handed to a pin cell
  typedef struct packed {
    logic dir;
    logic lat;
    logic odc;
    logic ana;
    logic pu;
    logic pd;
  } gpcn_cfg_t;

  // per-pin pad control towards the pad ring
  typedef struct packed {
    logic out;
    logic oe;
    logic puEn;
    logic pdEn;
    logic analogEn;
  } gpcn_pad_t;

endpackage

// [rtl/gpcn_pin_cell.sv]
// one port pin: pad drive, read masking and change compare
`timescale 1ns/1ps
module gpcn_pin_cell
  import gpcn_pkg::*;
(
  input  wire gpcn_pkg::gpcn_cfg_t cfg,
  input  wire logic                own,
  input  wire logic                periphOut,
  input  wire logic                periphOe,
  input  wire logic                sample,
  input  wire logic                prev,
  output gpcn_pkg::gpcn_pad_t      pad,
  output logic                     readBit,
  output logic                     changed
);

  // pad drive, peripheral takes the pin when it owns it
  always_comb
  begin
    pad          = '0;
    pad.puEn     = cfg.pu;
    pad.pdEn     = cfg.pd;
    pad.analogEn = cfg.ana;
    if (own)
    begin
      pad.out = periphOut;
      pad.oe  = periphOe;
    end
    else if (cfg.odc)
    begin
      pad.out = 1'b0;
      pad.oe  = ~cfg.dir & ~cfg.lat;
    end
    else
    begin
      pad.out = cfg.lat;
      pad.oe  = ~cfg.dir;
    end
  end

  // analog inputs read low, digital inputs give the sampled level
  assign readBit = sample & ~(cfg.ana & cfg.dir);

  // any level change since the previous sample
  assign changed = sample ^ prev;

endmodule

// [rtl/gpcn_port.sv]
// gpio port with change notification and apb register access
//
// Function
// - direction bit 1 input, 0 output
// - all pins come up as inputs
// - latch reads latch, writes latch
// - level reads pins, writes go to latch
// - open-drain drives low, releases high
// - analog select resets to all ones
// - analog inputs read as zero on level
// - output still driven while analog selected
// - digital input reads only digital value
// - peripheral-owned pin is not gpio
// - ten registers control each pin
// - enabled pin change raises interrupt request
// - change detection needs no gated clock
// - status marks change since last level read
// - independent weak pull-up and pull-down enables
// - clear, set, invert touch only one bits
// - companions at base plus 4, 8, 12
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module gpcn_port
  import gpcn_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [gpcn_pkg::GPCN_PINS-1:0] pinIn,
  input  wire logic [gpcn_pkg::GPCN_PINS-1:0] periphOwn,
  input  wire logic [gpcn_pkg::GPCN_PINS-1:0] periphOut,
  input  wire logic [gpcn_pkg::GPCN_PINS-1:0] periphOe,
  output gpcn_pkg::gpcn_pad_t [gpcn_pkg::GPCN_PINS-1:0] pad,
  output logic                                cnIrq
);

  import gpcn_pkg::*;

  // whole module state
  typedef struct packed {
    logic [15:0] analog;
    logic [15:0] dir;
    logic [15:0] lat;
    logic [15:0] odc;
    logic [15:0] pu;
    logic [15:0] pd;
    logic [15:0] cnCtl;
    logic [15:0] cnEn;
    logic [15:0] cnStat;
    logic [15:0] pinSample;
    logic [15:0] pinPrev;
    logic [31:0] rdData;
    logic        errFlag;
    logic        irq;
  } gpcn_state_t;

  localparam gpcn_state_t GPCN_RST_STATE = '{
    analog:    GPCN_RST_ANALOG,
    dir:       GPCN_RST_DIR,
    lat:       GPCN_RST_ZERO,
    odc:       GPCN_RST_ZERO,
    pu:        GPCN_RST_ZERO,
    pd:        GPCN_RST_ZERO,
    cnCtl:     GPCN_RST_ZERO,
    cnEn:      GPCN_RST_ZERO,
    cnStat:    GPCN_RST_ZERO,
    pinSample: GPCN_RST_ZERO,
    pinPrev:   GPCN_RST_ZERO,
    rdData:    32'h0000_0000,
    errFlag:   1'b0,
    irq:       1'b0
  };

  gpcn_state_t                stReg;
  gpcn_state_t                stNext;
  logic        [GPCN_PINS-1:0] readBits;
  logic        [GPCN_PINS-1:0] changedBits;
  logic        [11:0]          baseAddr;
  gpcn_op_t                    accOp;
  logic                        addrHit;
  logic                        setupPhase;
  logic                        accessPhase;
  logic        [15:0]          readMux;
  logic        [15:0]          wrData;
  logic        [15:0]          setMask;
  logic                        cnOn;

  // apply a plain write or a clear, set, invert companion
  function automatic logic [15:0] apply_op(input logic [15:0] old,
                                           input logic [15:0] val,
                                           input gpcn_op_t    op);
    logic [15:0] res;
    res = old;
    case (op)
      GPCN_OP_WRITE: res = val;
      GPCN_OP_CLR:   res = old & ~val;
      GPCN_OP_SET:   res = old | val;
      GPCN_OP_INV:   res = old ^ val;
      default:       res = old;
    endcase
    return res;
  endfunction

  // one cell per pin
  generate
    for (genvar i = 0; i < GPCN_PINS; i++)
    begin : g_pin
      gpcn_cfg_t cellCfg;
      assign cellCfg = '{dir: stReg.dir[i], lat: stReg.lat[i], odc: stReg.odc[i],
                         ana: stReg.analog[i], pu: stReg.pu[i], pd: stReg.pd[i]};
      gpcn_pin_cell u_cell (
        .cfg       (cellCfg),
        .own       (periphOwn[i]),
        .periphOut (periphOut[i]),
        .periphOe  (periphOe[i]),
        .sample    (stReg.pinSample[i]),
        .prev      (stReg.pinPrev[i]),
        .pad       (pad[i]),
        .readBit   (readBits[i]),
        .changed   (changedBits[i])
      );
    end
  endgenerate

  // address split: base register and companion kind
  assign baseAddr    = {paddr[11:4], 4'h0};
  assign accOp       = gpcn_op_t'(paddr[3:2]);
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrData      = pwdata[15:0];
  assign cnOn        = stReg.cnCtl[GPCN_CNON_BIT];

  // address decode and read data selection
  always_comb
  begin
    addrHit = 1'b1;
    readMux = 16'h0000;
    if (paddr[1:0] != 2'b00)
    begin
      addrHit = 1'b0;
    end
    else if (baseAddr == GPCN_OFF_ANALOG)
    begin
      readMux = stReg.analog;
    end
    else if (baseAddr == GPCN_OFF_DIR)
    begin
      readMux = stReg.dir;
    end
    else if (baseAddr == GPCN_OFF_LEVEL)
    begin
      readMux = readBits;
    end
    else if (baseAddr == GPCN_OFF_LATCH)
    begin
      readMux = stReg.lat;
    end
    else if (baseAddr == GPCN_OFF_ODC)
    begin
      readMux = stReg.odc;
    end
    else if (baseAddr == GPCN_OFF_PU)
    begin
      readMux = stReg.pu;
    end
    else if (baseAddr == GPCN_OFF_PD)
    begin
      readMux = stReg.pd;
    end
    else if (baseAddr == GPCN_OFF_CNCTL)
    begin
      readMux = stReg.cnCtl;
    end
    else if (baseAddr == GPCN_OFF_CNEN)
    begin
      readMux = stReg.cnEn;
    end
    else if (baseAddr == GPCN_OFF_CNSTAT)
    begin
      readMux = stReg.cnStat;
    end
    else
    begin
      addrHit = 1'b0;
    end
    // companions read as zero
    if (accOp != GPCN_OP_WRITE)
    begin
      readMux = 16'h0000;
    end
  end

  // next state: sampling, register writes, change status
  always_comb
  begin
    stNext           = stReg;
    // pins are sampled every cycle, no clock gate in the path
    stNext.pinSample = pinIn;
    stNext.pinPrev   = stReg.pinSample;
    setMask          = changedBits & stReg.cnEn & {16{cnOn}};

    // setup cycle: capture read data and error answer
    if (setupPhase)
    begin
      stNext.rdData  = {16'h0000, readMux};
      stNext.errFlag = ~addrHit;
    end

    // access cycle: writes take effect
    if (accessPhase && pwrite && addrHit)
    begin
      if (baseAddr == GPCN_OFF_ANALOG)
      begin
        stNext.analog = apply_op(stReg.analog, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_DIR)
      begin
        stNext.dir = apply_op(stReg.dir, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_LEVEL)
      begin
        stNext.lat = apply_op(stReg.lat, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_LATCH)
      begin
        stNext.lat = apply_op(stReg.lat, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_ODC)
      begin
        stNext.odc = apply_op(stReg.odc, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_PU)
      begin
        stNext.pu = apply_op(stReg.pu, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_PD)
      begin
        stNext.pd = apply_op(stReg.pd, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_CNCTL)
      begin
        stNext.cnCtl = apply_op(stReg.cnCtl, wrData, accOp);
      end
      else if (baseAddr == GPCN_OFF_CNEN)
      begin
        stNext.cnEn = apply_op(stReg.cnEn, wrData, accOp);
      end
      else
      begin
        stNext.cnStat = apply_op(stReg.cnStat, wrData, accOp);
      end
    end

    // a read of the pin level register restarts change tracking
    if (accessPhase && !pwrite && baseAddr == GPCN_OFF_LEVEL && accOp == GPCN_OP_WRITE
        && paddr[1:0] == 2'b00)
    begin
      stNext.cnStat = 16'h0000;
    end

    // a new change wins over any clear in the same cycle
    stNext.cnStat = stNext.cnStat | setMask;

    // single port-level request
    stNext.irq = |(stNext.cnStat & stNext.cnEn) & stNext.cnCtl[GPCN_CNON_BIT];
  end

  // state register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stReg <= GPCN_RST_STATE;
    end
    else
    begin
      stReg <= stNext;
    end
  end

  // apb answers: zero wait states
  assign pready  = 1'b1;
  assign prdata  = stReg.rdData;
  assign pslverr = accessPhase & stReg.errFlag;
  assign cnIrq   = stReg.irq;

endmodule

// [testbench/gpcn_port_monitor.sv]
// assertions on the apb, pad and change-request pins of the port
`timescale 1ns/1ps
module gpcn_port_monitor
  import gpcn_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [15:0]               pinIn,
  input wire logic [15:0]               periphOwn,
  input wire logic [15:0]               periphOut,
  input wire logic [15:0]               periphOe,
  input wire gpcn_pkg::gpcn_pad_t [15:0] pad,
  input wire logic                      cnIrq
);
  logic [15:0] oeV;
  logic [15:0] outV;
  logic [15:0] anaV;

  // pad fields gathered into words
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      oeV[i] = pad[i].oe;
      outV[i] = pad[i].out;
      anaV[i] = pad[i].analogEn;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // apb phases
  sequence sSetup;
    psel && !penable;
  endsequence
  sequence sAccess;
    psel && penable;
  endsequence

  chk_zero_wait: assert property (sSetup ##1 sAccess |-> pready)
    else $error("access not answered at once");
  chk_err_window: assert property (pslverr |-> sAccess)
    else $error("error flag outside access");
  chk_err_misalign: assert property (sAccess and (paddr[1:0] != 2'b00)
    |-> pslverr && prdata == 0)
    else $error("misaligned access not refused");
  chk_base_ok: assert property (sAccess and (paddr[1:0] == 2'b00 && paddr <= 12'h09C)
    |-> !pslverr)
    else $error("mapped access refused");
  chk_reset_vals: assert property (disable iff (1'b0) !rst_n |=> !cnIrq && anaV == 16'hFFFF
    && (oeV & ~periphOwn) == 16'h0000)
    else $error("reset state wrong");
  chk_owned_drive: assert property ((oeV & periphOwn) == (periphOe & periphOwn)
    && (outV & periphOwn) == (periphOut & periphOwn))
    else $error("owned pin not given to peripheral");
  chk_irq_cause: assert property ($rose(cnIrq) && !$past(psel && pwrite)
    |-> $past(pinIn, 2) != $past(pinIn, 3))
    else $error("request without pin change");
  chk_irq_clear: assert property ($fell(cnIrq) |-> $past(psel && penable) || !$past(rst_n))
    else $error("request dropped without access");
endmodule

bind gpcn_port gpcn_port_monitor gpcn_port_monitor_inst (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pinIn, .periphOwn, .periphOut, .periphOe, .pad, .cnIrq);

// [testbench/gpcn_ext.sv]
// model of the devices and resistors hung on the port pins
`timescale 1ns/1ps
module gpcn_ext
  import gpcn_pkg::*;
(
  input  wire logic                      clk,
  input  wire gpcn_pkg::gpcn_pad_t [15:0] pad,
  input  wire logic [15:0]               extVal,
  input  wire logic [15:0]               extEn,
  output logic [15:0]                    pinIn
);
  initial pinIn = 16'h0000;

  // resolve each pin once a clock; a floating pin toggles
  always @(posedge clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (pad[i].oe)
        pinIn[i] <= pad[i].out;
      else if (extEn[i])
        pinIn[i] <= extVal[i];
      else if (pad[i].puEn)
        pinIn[i] <= 1'b1;
      else if (pad[i].pdEn)
        pinIn[i] <= 1'b0;
      else
        pinIn[i] <= ~pinIn[i];
    end
  end
endmodule

// [testbench/tb.sv]
// self-checking bench for the gpio port with change notification
`timescale 1ns/1ps
module tb;
  import gpcn_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [15:0]      pinIn;
  logic [15:0]      periphOwn = 16'h0;
  logic [15:0]      periphOut = 16'h0;
  logic [15:0]      periphOe = 16'h0;
  logic [15:0]      extVal = 16'h0;
  logic [15:0]      extEn = 16'h0;
  gpcn_pad_t [15:0] pad;
  logic             cnIrq;
  logic [15:0]      oeV;
  logic [31:0]      rdat;
  logic             err;
  int               mismatches = 0;
  int               numChecks = 0;

  always #20 clk = ~clk;

  // pad enables gathered into one word
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      oeV[i] = pad[i].oe;
  end

  gpcn_port gpcn_port_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pinIn, .periphOwn, .periphOut, .periphOe, .pad, .cnIrq);
  gpcn_ext gpcn_ext_inst (.clk, .pad, .extVal, .extEn, .pinIn);

  task final_report;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer, setup then access until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      mismatches++;
      final_report();
    end
    @(posedge clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rdat, e);
  endtask

  task idle;
    repeat (3) @(posedge clk);
  endtask

  task t_map;
    cmp({16'h0, oeV}, 32'h0);
    rd(GPCN_OFF_DIR, 32'hFFFF);
    rd(GPCN_OFF_ANALOG, 32'hFFFF);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, 12'(i * 16), 32'h0);
      cmp({31'h0, err}, 32'h0);
    end
    apb(1'b0, 12'h0A0, 32'h0);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, 12'h012, 32'h0);
    cmp({31'h0, err}, 32'h1);
    rd(GPCN_OFF_DIR, 32'hFFFF);
    $display("map test done");
  endtask

  task t_io;
    wr(GPCN_OFF_ANALOG, 32'h0);
    wr(GPCN_OFF_DIR, 32'hFF00);
    extVal <= 16'h5A00;
    extEn <= 16'hFF00;
    wr(GPCN_OFF_LEVEL, 32'hA5C3);
    rd(GPCN_OFF_LATCH, 32'hA5C3);
    idle();
    rd(GPCN_OFF_LEVEL, 32'h5AC3);
    cmp({16'h0, oeV}, 32'h00FF);
    wr(GPCN_OFF_LATCH + GPCN_OFF_SET, 32'hF000);
    wr(GPCN_OFF_LATCH + GPCN_OFF_CLR, 32'h00C3);
    wr(GPCN_OFF_LATCH + GPCN_OFF_INV, 32'h003C);
    rd(GPCN_OFF_LATCH, 32'hF53C);
    $display("io test done");
  endtask

  task t_pads;
    extVal <= 16'h5A04;
    extEn <= 16'hFF04;
    wr(GPCN_OFF_ODC, 32'h0004);
    idle();
    cmp({16'h0, oeV}, 32'h00FB);
    rd(GPCN_OFF_LEVEL, 32'h5A3C);
    wr(GPCN_OFF_LATCH + GPCN_OFF_CLR, 32'h0004);
    idle();
    cmp({16'h0, oeV}, 32'h00FF);
    rd(GPCN_OFF_LEVEL, 32'h5A38);
    extEn <= 16'h3F04;
    wr(GPCN_OFF_PU, 32'h8000);
    wr(GPCN_OFF_PD, 32'h4000);
    idle();
    cmp({pad[15].puEn, pad[15].pdEn, pad[14].puEn, pad[14].pdEn}, 32'h9);
    rd(GPCN_OFF_LEVEL, 32'h9A38);
    wr(GPCN_OFF_ANALOG + GPCN_OFF_SET, 32'h0202);
    idle();
    rd(GPCN_OFF_LEVEL, 32'h9838);
    cmp({16'h0, oeV}, 32'h00FF);
    wr(GPCN_OFF_ANALOG + GPCN_OFF_CLR, 32'h0202);
    periphOwn <= 16'h0100;
    periphOe <= 16'h0100;
    periphOut <= 16'h0100;
    idle();
    cmp({pad[8].oe, pad[8].out}, 32'h3);
    periphOwn <= 16'h0;
    $display("pad test done");
  endtask

  task t_notify;
    int n;
    wr(GPCN_OFF_CNCTL, 32'h8000);
    wr(GPCN_OFF_CNEN, 32'h0800);
    extVal <= 16'h5604;
    n = 0;
    while (cnIrq !== 1'b1 && n < 10)
    begin
      n++;
      @(posedge clk);
    end
    cmp({31'h0, cnIrq}, 32'h1);
    rd(GPCN_OFF_CNSTAT, 32'h0800);
    rd(GPCN_OFF_LEVEL, 32'h9638);
    idle();
    cmp({31'h0, cnIrq}, 32'h0);
    rd(GPCN_OFF_CNSTAT, 32'h0);
    $display("notify test done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_map();
    t_io();
    t_pads();
    t_notify();
    final_report();
  end
endmodule
